/* sspr_checker.sv */
`timescale 1ns/10ps
module sspr_checker
	import sspr_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
)
(
	// Clock and bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Pins and interrupts
	input wire logic sclk_oe,
	input wire logic frame_out,
	input wire logic frame_oe,
	input wire logic serial_out_oe,
	input wire logic overrun_irq,
	input wire logic tx_service_irq,
	input wire logic rx_service_irq
);
	logic wr_pend;
	logic [31:0] wr_addr;
	logic [6:0] ctl;
	logic [1:0] fmt;
	logic [1:0] age;
	logic take;
	logic quiet;
	assign take = hsel && hready && htrans[1];
	assign quiet = (age == 2'h3);
	// Shadow of port control, role frozen while enabled
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 32'h0;
			ctl <= 7'h00;
			fmt <= FMT_SPI;
			age <= 2'h0;
		end
		else
		begin
			wr_pend <= take && hwrite;
			wr_addr <= haddr;
			if (wr_pend && wr_addr == ADDR_PORT_CONTROL)
				ctl <= {hwdata[SOD_BIT], ctl[ENABLE_BIT] ? ctl[ROLE_BIT] : hwdata[ROLE_BIT],
					hwdata[4:0]};
			if (wr_pend && wr_addr == ADDR_FRAME_CONTROL)
				fmt <= hwdata[FORMAT_MSB:FORMAT_LSB];
			age <= wr_pend ? 2'h0 : (age == 2'h3) ? age : age + 2'h1;
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not OKAY");
	a_frame_idle: assert property (quiet && !ctl[ENABLE_BIT] && !ctl[ROLE_BIT] |->
		frame_out == (fmt != FMT_SSI))
		else $error("frame active while disabled");
	a_slave_quiet: assert property (quiet && ctl[ROLE_BIT] && ctl[SOD_BIT] |-> !serial_out_oe)
		else $error("disabled slave drives data");
	a_master_pins: assert property (quiet && !ctl[ROLE_BIT] |-> sclk_oe && frame_oe)
		else $error("master pins not enabled");
	a_rx_masked: assert property (quiet && !ctl[RIE_BIT] |-> !rx_service_irq)
		else $error("rx irq while masked");
	a_tx_masked: assert property (quiet && !ctl[TIE_BIT] |-> !tx_service_irq)
		else $error("tx irq while masked");
	a_ovr_masked: assert property (quiet && !ctl[OVERRUN_IRQ_ENABLE_BIT] |-> !overrun_irq)
		else $error("overrun irq while masked");
	a_ovr_clear: assert property (wr_pend && wr_addr == ADDR_IRQ_STATUS_CLEAR |-> ##[1:2] !overrun_irq)
		else $error("overrun not cleared by write");
	a_rdata_hold: assert property ($changed(hrdata) |-> $past(take && !hwrite))
		else $error("read data changed without read");
endmodule : sspr_checker
bind sspr_top sspr_checker #(.FIFO_DEPTH(FIFO_DEPTH)) i_checker (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sclk_oe(sclk_oe),
	.frame_out(frame_out), .frame_oe(frame_oe), .serial_out_oe(serial_out_oe),
	.overrun_irq(overrun_irq), .tx_service_irq(tx_service_irq), .rx_service_irq(rx_service_irq));

/* sspr_far_slave.sv */
`timescale 1ns/10ps
module sspr_far_slave
(
	// Clock and serial pins
	input wire logic hclk,
	input wire logic sclk,
	input wire logic frame_n,
	input wire logic mosi,
	output logic miso,
	// Reply and capture
	input wire logic [15:0] reply,
	input wire logic [4:0] word_len,
	output logic [15:0] rx_word
);
	logic [15:0] tx_sh = 16'h0;
	logic idle_bit = 1'b0;
	// Reply loaded MSB first at frame start
	always @(negedge frame_n)
		tx_sh <= reply << (5'h10 - word_len);
	always @(negedge sclk)
		if (!frame_n)
			tx_sh <= tx_sh << 1;
	// Capture on rising clock, MSB first
	always @(posedge sclk)
		if (!frame_n)
			rx_word <= {rx_word[14:0], mosi};
	// Released line toggles outside frames
	always @(posedge hclk)
		idle_bit <= ~idle_bit;
	assign miso = frame_n ? idle_bit : tx_sh[15];
endmodule : sspr_far_slave

/* sspr_pkg.sv */
// Notes on behaviour
// RULE_01: Bit rate is the prescaled clock divided by one plus the rate divisor.
// RULE_02: Frame format 00 SPI, 01 framed synchronous serial, 10 three-wire; 11 undefined.
// RULE_03: Word size code 0011 gives 4 bits up to 1111 giving 16 bits.
// RULE_04: Clock phase and polarity act only in SPI framing.
// RULE_05: A slave with output disable set never drives the transmit line.
// RULE_06: Software changes the role only while disabled; 0 master, 1 slave.
// RULE_07: Port enable 0 stops all serial activity; 1 allows transfers.
// RULE_08: Loopback feeds the transmit shifter output into the receive shifter.
// RULE_09: Receive overrun raises its interrupt only while its enable is set.
// RULE_10: Transmit interrupt holds while enabled and transmit FIFO is half full or emptier.
// RULE_11: Receive interrupt holds while enabled and receive FIFO is half full or fuller.
// RULE_12: Data register reads pop the receive FIFO; received words enter at its tail.
// RULE_13: Data register writes push the transmit FIFO; the shifter drains it word by word.
// RULE_14: Software right-aligns short transmit words; upper bits are ignored.
// RULE_15: Short received words are right-aligned in the receive FIFO.
// RULE_16: Three-wire mode sends only the low byte; receive length follows word size.
// RULE_17: Clearing port enable flushes neither FIFO.
// RULE_18: The interrupt address reads status and clears on writes.
// RULE_19: Reserved register bits read undefined; here they read zero.
// RULE_20: Prescale divisor is even, 2 to 254; bit zero reads back as zero.
// RULE_21: Any write to the interrupt clear address clears the overrun interrupt.
// RULE_22: Receive request at four or more words; transmit request with four free.
// RULE_23: Busy reads 1 during a frame or while the transmit FIFO holds data.
// RULE_24: Transmit and receive FIFOs are eight deep and 16 bits wide.
// RULE_25: Serial clock is reference over prescale times one plus rate divisor.
package sspr_pkg;
	localparam logic [31:0] ADDR_FRAME_CONTROL = 32'h808A_0000;
	localparam logic [31:0] ADDR_PORT_CONTROL = 32'h808A_0004;
	localparam logic [31:0] ADDR_FIFO_DATA = 32'h808A_0008;
	localparam logic [31:0] ADDR_FIFO_STATUS = 32'h808A_000C;
	localparam logic [31:0] ADDR_CLOCK_PRESCALE = 32'h808A_0010;
	localparam logic [31:0] ADDR_IRQ_STATUS_CLEAR = 32'h808A_0014;
	localparam logic [15:0] FRAME_CONTROL_RESET = 16'h0000;
	localparam logic [6:0] PORT_CONTROL_RESET = 7'h00;
	localparam logic [7:0] CLOCK_PRESCALE_RESET = 8'h00;
	// Frame control fields
	localparam int RATE_LSB = 8;
	localparam int RATE_MSB = 15;
	localparam int PHASE_BIT = 7;
	localparam int POLARITY_BIT = 6;
	localparam int FORMAT_LSB = 4;
	localparam int FORMAT_MSB = 5;
	localparam int SIZE_LSB = 0;
	localparam int SIZE_MSB = 3;
	// Port control fields
	localparam int SOD_BIT = 6;
	localparam int ROLE_BIT = 5;
	localparam int ENABLE_BIT = 4;
	localparam int LOOP_BIT = 3;
	localparam int OVERRUN_IRQ_ENABLE_BIT = 2;
	localparam int TIE_BIT = 1;
	localparam int RIE_BIT = 0;
	// Status and interrupt fields
	localparam int BUSY_BIT = 4;
	localparam int RFF_BIT = 3;
	localparam int RNE_BIT = 2;
	localparam int TNF_BIT = 1;
	localparam int TFE_BIT = 0;
	localparam int RORIS_BIT = 2;
	localparam int TIS_BIT = 1;
	localparam int RIS_BIT = 0;
	// Frame formats
	localparam logic [1:0] FMT_SPI = 2'h0;
	localparam logic [1:0] FMT_SSI = 2'h1;
	localparam logic [1:0] FMT_TW = 2'h2;
	// Word lengths
	localparam int WORD_W = 16;
	localparam logic [4:0] WORD_W_5 = 5'h10;
	localparam logic [4:0] TW_CTRL_BITS = 5'h08;
	localparam logic [5:0] TW_RX_FIRST = 6'h09;
	localparam logic [7:0] PRESCALE_MIN = 8'h02;
	typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_XFER, ST_TAIL} sspr_state_t;
endpackage : sspr_pkg

/* sspr_top.sv */
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
module sspr_top
	import sspr_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
)
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Serial pins in
	input wire logic sclk_in,
	input wire logic frame_in,
	input wire logic rxd_in,
	// Serial pins out
	output logic sclk_out,
	output logic sclk_oe,
	output logic frame_out,
	output logic frame_oe,
	output logic serial_out_line,
	output logic serial_out_oe,
	// Interrupt lines
	output logic overrun_irq,
	output logic tx_service_irq,
	output logic rx_service_irq
);
	localparam int PW = $clog2(FIFO_DEPTH);
	localparam logic [PW:0] FIFO_FULL = (PW + 1)'(FIFO_DEPTH);
	localparam logic [PW:0] FIFO_HALF = (PW + 1)'(FIFO_DEPTH / 2);

	generate
		if (FIFO_DEPTH < 2 || (1 << PW) != FIFO_DEPTH)
		begin : g_bad_depth
			$error("FIFO_DEPTH must be a power of two of at least 2");
		end
	endgenerate

	function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
		hit = (a == b);
	endfunction : hit

	logic [15:0] frame_control_reg;
	logic [6:0] port_control_reg;
	logic [7:0] clock_prescale_reg;
	logic [31:0] wr_addr_reg;
	logic wr_pend_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] rd_word;
	logic addr_phase;

	// Control fields
	logic [7:0] bit_rate_divisor;
	logic clock_phase_sel, clock_polarity_sel;
	logic [1:0] frame_format_sel;
	logic [3:0] word_size_sel;
	logic slave_output_disable, role_select, port_enable, loopback_sel;
	logic overrun_irq_enable, tx_irq_enable, rx_irq_enable;
	assign bit_rate_divisor = frame_control_reg[RATE_MSB:RATE_LSB];
	assign clock_phase_sel = frame_control_reg[PHASE_BIT];
	assign clock_polarity_sel = frame_control_reg[POLARITY_BIT];
	assign frame_format_sel = frame_control_reg[FORMAT_MSB:FORMAT_LSB];
	assign word_size_sel = frame_control_reg[SIZE_MSB:SIZE_LSB];
	assign slave_output_disable = port_control_reg[SOD_BIT];
	assign role_select = port_control_reg[ROLE_BIT];
	assign port_enable = port_control_reg[ENABLE_BIT];
	assign loopback_sel = port_control_reg[LOOP_BIT];
	assign overrun_irq_enable = port_control_reg[OVERRUN_IRQ_ENABLE_BIT];
	assign tx_irq_enable = port_control_reg[TIE_BIT];
	assign rx_irq_enable = port_control_reg[RIE_BIT];

	// FIFO storage
	logic [WORD_W-1:0] tx_mem [FIFO_DEPTH];
	logic [WORD_W-1:0] rx_mem [FIFO_DEPTH];
	logic [PW-1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
	logic [PW:0] tx_cnt_reg, rx_cnt_reg;
	logic tx_push, tx_pop, rx_push, rx_pop, tx_empty, tx_full, rx_empty, rx_full;
	logic [WORD_W-1:0] rx_word;
	assign tx_empty = (tx_cnt_reg == '0);
	assign tx_full = (tx_cnt_reg == FIFO_FULL);
	assign rx_empty = (rx_cnt_reg == '0);
	assign rx_full = (rx_cnt_reg == FIFO_FULL);

	// Bus slave
	assign addr_phase = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 32'h0000_0000;
		end
		else
		begin
			wr_pend_reg <= addr_phase & hwrite;
			if (addr_phase)
				wr_addr_reg <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_reg <= 32'h0000_0000;
		else if (addr_phase & !hwrite)
			hrdata_reg <= rd_word;
	end

	// Read mux, reserved bits zero
	sspr_state_t state_reg;
	logic busy_flag;
	always_comb
	begin
		rd_word = 32'h0000_0000; // [RULE_19]
		if (hit(haddr, ADDR_FRAME_CONTROL))
			rd_word[15:0] = frame_control_reg;
		else if (hit(haddr, ADDR_PORT_CONTROL))
			rd_word[6:0] = port_control_reg;
		else if (hit(haddr, ADDR_FIFO_DATA) && !rx_empty)
			rd_word[WORD_W-1:0] = rx_mem[rx_rp_reg]; // [RULE_12]
		else if (hit(haddr, ADDR_FIFO_STATUS))
		begin
			rd_word[BUSY_BIT] = busy_flag; // [RULE_23]
			rd_word[RFF_BIT] = rx_full;
			rd_word[RNE_BIT] = !rx_empty;
			rd_word[TNF_BIT] = !tx_full;
			rd_word[TFE_BIT] = tx_empty;
		end
		else if (hit(haddr, ADDR_CLOCK_PRESCALE))
			rd_word[7:0] = clock_prescale_reg;
		else if (hit(haddr, ADDR_IRQ_STATUS_CLEAR))
		begin
			rd_word[RORIS_BIT] = overrun_irq; // [RULE_18]
			rd_word[TIS_BIT] = tx_service_irq;
			rd_word[RIS_BIT] = rx_service_irq;
		end
	end

	assign rx_pop = addr_phase & !hwrite & hit(haddr, ADDR_FIFO_DATA) & !rx_empty; // [RULE_12]
	assign tx_push = wr_pend_reg & hit(wr_addr_reg, ADDR_FIFO_DATA); // [RULE_13]

	// Register writes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			frame_control_reg <= FRAME_CONTROL_RESET;
		else if (wr_pend_reg & hit(wr_addr_reg, ADDR_FRAME_CONTROL))
			frame_control_reg <= hwdata[15:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			port_control_reg <= PORT_CONTROL_RESET;
		else if (wr_pend_reg & hit(wr_addr_reg, ADDR_PORT_CONTROL))
		begin
			port_control_reg <= hwdata[6:0];
			if (port_enable)
				port_control_reg[ROLE_BIT] <= role_select; // [RULE_06]
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			clock_prescale_reg <= CLOCK_PRESCALE_RESET;
		else if (wr_pend_reg & hit(wr_addr_reg, ADDR_CLOCK_PRESCALE))
			clock_prescale_reg <= {hwdata[7:1], 1'b0}; // [RULE_20]
	end

	// Transmit FIFO, kept across disable
	always_ff @(posedge hclk)
	begin
		if (tx_push & !tx_full)
			tx_mem[tx_wp_reg] <= hwdata[WORD_W-1:0]; // [RULE_13] [RULE_14]
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_wp_reg <= '0;
			tx_rp_reg <= '0;
			tx_cnt_reg <= '0;
		end
		else
		begin
			if (tx_push & !tx_full)
				tx_wp_reg <= tx_wp_reg + 1'b1;
			if (tx_pop)
				tx_rp_reg <= tx_rp_reg + 1'b1; // [RULE_17]
			case ({tx_push & !tx_full, tx_pop})
				2'b10: tx_cnt_reg <= tx_cnt_reg + 1'b1;
				2'b01: tx_cnt_reg <= tx_cnt_reg - 1'b1;
				default: tx_cnt_reg <= tx_cnt_reg;
			endcase
		end
	end

	// Receive FIFO
	always_ff @(posedge hclk)
	begin
		if (rx_push & !rx_full)
			rx_mem[rx_wp_reg] <= rx_word; // [RULE_12] [RULE_24]
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_wp_reg <= '0;
			rx_rp_reg <= '0;
			rx_cnt_reg <= '0;
		end
		else
		begin
			if (rx_push & !rx_full)
				rx_wp_reg <= rx_wp_reg + 1'b1;
			if (rx_pop)
				rx_rp_reg <= rx_rp_reg + 1'b1;
			case ({rx_push & !rx_full, rx_pop})
				2'b10: rx_cnt_reg <= rx_cnt_reg + 1'b1;
				2'b01: rx_cnt_reg <= rx_cnt_reg - 1'b1;
				default: rx_cnt_reg <= rx_cnt_reg;
			endcase
		end
	end

	// Pin synchronisers
	logic sclk_m1_reg, sclk_s_reg, sclk_prev_reg;
	logic frame_m1_reg, frame_s_reg, rxd_m1_reg, rxd_s_reg;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			{sclk_m1_reg, sclk_s_reg, sclk_prev_reg} <= 3'h0;
			{frame_m1_reg, frame_s_reg, rxd_m1_reg, rxd_s_reg} <= 4'h0;
		end
		else
		begin
			sclk_m1_reg <= sclk_in;
			sclk_s_reg <= sclk_m1_reg;
			sclk_prev_reg <= sclk_s_reg;
			frame_m1_reg <= frame_in;
			frame_s_reg <= frame_m1_reg;
			rxd_m1_reg <= rxd_in;
			rxd_s_reg <= rxd_m1_reg;
		end
	end

	// Format decode
	logic fmt_spi, fmt_ssi, fmt_tw, eff_cpha, eff_cpol, is_master;
	logic [4:0] word_len, tx_len;
	logic [5:0] total_bits, rx_first;
	assign fmt_spi = (frame_format_sel == FMT_SPI); // [RULE_02]
	assign fmt_ssi = (frame_format_sel == FMT_SSI);
	assign fmt_tw = (frame_format_sel == FMT_TW);
	assign eff_cpha = fmt_spi ? clock_phase_sel : fmt_ssi; // [RULE_04]
	assign eff_cpol = fmt_spi & clock_polarity_sel; // [RULE_04]
	assign is_master = !role_select; // [RULE_06]
	assign word_len = {1'b0, word_size_sel} + 5'h01; // [RULE_03]
	assign tx_len = fmt_tw ? TW_CTRL_BITS : word_len; // [RULE_16]
	assign total_bits = fmt_tw ? (TW_RX_FIRST + {1'b0, word_len}) : {1'b0, word_len};
	assign rx_first = fmt_tw ? TW_RX_FIRST : 6'h00;

	// Bit rate divider
	logic [7:0] prescale_divisor;
	logic [6:0] pre_last, pre_cnt_reg;
	logic [7:0] rate_cnt_reg;
	logic half_tick, half_reg;
	assign prescale_divisor = (clock_prescale_reg < PRESCALE_MIN) ? PRESCALE_MIN
		: clock_prescale_reg;
	assign pre_last = prescale_divisor[7:1] - 7'h01;
	assign half_tick = (state_reg != ST_IDLE) & (pre_cnt_reg == pre_last)
		& (rate_cnt_reg == bit_rate_divisor); // [RULE_01] [RULE_25]

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pre_cnt_reg <= 7'h00;
			rate_cnt_reg <= 8'h00;
		end
		else if (state_reg == ST_IDLE || !is_master)
		begin
			pre_cnt_reg <= 7'h00;
			rate_cnt_reg <= 8'h00;
		end
		else if (pre_cnt_reg == pre_last)
		begin
			pre_cnt_reg <= 7'h00;
			rate_cnt_reg <= (rate_cnt_reg == bit_rate_divisor) ? 8'h00
				: rate_cnt_reg + 8'h01; // [RULE_01]
		end
		else
			pre_cnt_reg <= pre_cnt_reg + 7'h01;
	end

	// Sample and shift events
	logic s_rise, s_fall, cap_ev, launch_ev, m_start, s_start, last_cap, frame_on;
	logic [5:0] pos_reg;
	logic [WORD_W-1:0] tx_sh_reg, rx_sh_reg, tx_load, rx_mask;
	logic rx_bit, tx_bit;
	assign s_rise = (sclk_s_reg ^ eff_cpol) & !(sclk_prev_reg ^ eff_cpol);
	assign s_fall = !(sclk_s_reg ^ eff_cpol) & (sclk_prev_reg ^ eff_cpol);
	always_comb
	begin
		if (is_master)
		begin
			cap_ev = (state_reg == ST_XFER) & half_tick & !half_reg;
			launch_ev = (state_reg == ST_XFER) & half_tick & half_reg;
		end
		else
		begin
			cap_ev = port_enable & (eff_cpha ? s_fall : s_rise);
			launch_ev = port_enable & (eff_cpha ? s_rise : s_fall);
		end
	end
	assign frame_on = fmt_ssi ? frame_s_reg : !frame_s_reg;
	assign m_start = port_enable & is_master & (state_reg == ST_IDLE) & !tx_empty; // [RULE_07]
	assign s_start = port_enable & !is_master & (state_reg == ST_IDLE) & frame_on
		& (!fmt_ssi | cap_ev);
	assign tx_pop = m_start | (s_start & !tx_empty); // [RULE_13]
	assign last_cap = cap_ev & (state_reg == ST_XFER) & (pos_reg == total_bits - 6'h01);
	assign rx_push = last_cap; // [RULE_12]
	assign tx_load = tx_mem[tx_rp_reg] << (WORD_W_5 - tx_len); // [RULE_14] [RULE_16]
	assign tx_bit = tx_sh_reg[WORD_W-1];
	assign rx_bit = loopback_sel ? tx_sh_reg[WORD_W-1] : rxd_s_reg; // [RULE_08]
	assign rx_mask = {WORD_W{1'b1}} >> (WORD_W_5 - word_len);
	assign rx_word = {rx_sh_reg[WORD_W-2:0], rx_bit} & rx_mask; // [RULE_15]
	assign busy_flag = (state_reg != ST_IDLE) | !tx_empty; // [RULE_23]

	// Frame engine
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= ST_IDLE;
			half_reg <= 1'b0;
			pos_reg <= 6'h00;
			tx_sh_reg <= '0;
			rx_sh_reg <= '0;
		end
		else if (!port_enable)
		begin
			state_reg <= ST_IDLE; // [RULE_07]
			half_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					if (m_start | s_start)
					begin
						state_reg <= m_start ? ST_LEAD : ST_XFER;
						half_reg <= 1'b0;
						pos_reg <= 6'h00;
						rx_sh_reg <= '0;
						tx_sh_reg <= tx_empty ? '0 : tx_load; // [RULE_13]
					end
				end
				ST_LEAD:
				begin
					if (half_tick)
					begin
						half_reg <= fmt_ssi & !half_reg;
						if (!fmt_ssi || half_reg)
							state_reg <= ST_XFER;
					end
				end
				ST_XFER:
				begin
					if (cap_ev)
					begin
						pos_reg <= pos_reg + 6'h01;
						if (pos_reg >= rx_first)
							rx_sh_reg <= {rx_sh_reg[WORD_W-2:0], rx_bit}; // [RULE_08]
						if (is_master)
							half_reg <= 1'b1;
						else if (last_cap)
							state_reg <= ST_IDLE;
					end
					if (launch_ev)
					begin
						if (pos_reg != 6'h00)
							tx_sh_reg <= {tx_sh_reg[WORD_W-2:0], 1'b0};
						if (is_master)
						begin
							half_reg <= 1'b0;
							if (pos_reg == total_bits)
								state_reg <= ST_TAIL;
						end
					end
					if (!is_master && !fmt_ssi && !frame_on)
						state_reg <= ST_IDLE;
				end
				ST_TAIL:
				begin
					if (half_tick)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Pin drivers
	logic sclk_lvl, frame_lvl;
	always_comb
	begin
		sclk_lvl = eff_cpol;
		if (state_reg == ST_XFER)
			sclk_lvl = (eff_cpha ? !half_reg : half_reg) ^ eff_cpol; // [RULE_04]
		if (fmt_ssi)
			frame_lvl = (state_reg == ST_LEAD);
		else
			frame_lvl = !((state_reg == ST_LEAD) | (state_reg == ST_XFER));
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sclk_out <= 1'b0;
			sclk_oe <= 1'b0;
			frame_out <= 1'b1;
			frame_oe <= 1'b0;
			serial_out_line <= 1'b0;
			serial_out_oe <= 1'b0;
		end
		else
		begin
			sclk_out <= sclk_lvl;
			sclk_oe <= is_master;
			frame_out <= frame_lvl;
			frame_oe <= is_master;
			serial_out_line <= (state_reg == ST_XFER) & tx_bit;
			serial_out_oe <= port_enable & (is_master
				| (!slave_output_disable & (state_reg == ST_XFER))); // [RULE_05]
		end
	end

	// Interrupt conditions
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			overrun_irq <= 1'b0;
		else if (rx_push & rx_full & overrun_irq_enable)
			overrun_irq <= 1'b1; // [RULE_09]
		else if ((wr_pend_reg & hit(wr_addr_reg, ADDR_IRQ_STATUS_CLEAR)) | !overrun_irq_enable)
			overrun_irq <= 1'b0; // [RULE_21] [RULE_18]
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_service_irq <= 1'b0;
			rx_service_irq <= 1'b0;
		end
		else
		begin
			tx_service_irq <= tx_irq_enable & (tx_cnt_reg <= FIFO_HALF); // [RULE_10] [RULE_22]
			rx_service_irq <= rx_irq_enable & (rx_cnt_reg >= FIFO_HALF); // [RULE_11] [RULE_22]
		end
	end
endmodule : sspr_top

/* sspr_top_tb.sv */
`timescale 1ns/10ps
module sspr_top_tb;
	import sspr_pkg::*;
	localparam int DEPTH = 8;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, d, v;
	logic hreadyout, hresp, sclk_out, sclk_oe, frame_out, frame_oe, miso;
	logic serial_out_line, serial_out_oe, overrun_irq, tx_service_irq, rx_service_irq;
	logic [15:0] reply = 16'h0;
	logic [4:0] word_len = 5'h10;
	logic [15:0] rx_word;
	logic [31:0] seed = 32'h48;
	logic [15:0] w [DEPTH];
	int n;
	int failures = 0;
	int total_checks = 0;
	always #50 hclk = ~hclk;
	sspr_top #(.FIFO_DEPTH(DEPTH)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sclk_in(1'b0), .frame_in(1'b1), .rxd_in(miso), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
		.frame_out(frame_out), .frame_oe(frame_oe), .serial_out_line(serial_out_line),
		.serial_out_oe(serial_out_oe), .overrun_irq(overrun_irq),
		.tx_service_irq(tx_service_irq), .rx_service_irq(rx_service_irq));
	sspr_far_slave i_far (.hclk(hclk), .sclk(sclk_out), .frame_n(frame_out),
		.mosi(serial_out_line), .miso(miso), .reply(reply), .word_len(word_len),
		.rx_word(rx_word));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [31:0] lowbits(input logic [31:0] x, input int k);
		return x & ((32'h1 << k) - 32'h1);
	endfunction : lowbits
	function automatic logic [31:0] status_of(input logic busy, input int rx, input int tx);
		return {27'h0, busy, rx == DEPTH, rx != 0, tx != DEPTH, tx == 0};
	endfunction : status_of
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] x,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= x;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(what, exp, r);
	endtask : rdchk
	task automatic wait_idle();
		int k;
		k = 0;
		d = 32'h10;
		while (d[BUSY_BIT] !== 1'b0 && k < 400)
		begin
			bus(1'b0, ADDR_FIFO_STATUS, 32'h0, d);
			k++;
		end
		chk("busy clear", 32'h0, {31'h0, d[BUSY_BIT]});
	endtask : wait_idle
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	initial
	begin
		repeat (60000) @(posedge hclk);
		failures++;
		summarize();
	end
	initial
	begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 6; i++)
			rdchk("reset", ADDR_FRAME_CONTROL + 32'(4 * i), (i == 3) ? status_of(1'b0, 0, 0) : 32'h0);
		// Random read-back
		for (int i = 0; i < 8; i++)
		begin
			v = rnd();
			bus(1'b1, ADDR_FRAME_CONTROL, v, d);
			rdchk("frame_control", ADDR_FRAME_CONTROL, lowbits(v, 16));
			bus(1'b1, ADDR_CLOCK_PRESCALE, v, d);
			rdchk("clock_prescale", ADDR_CLOCK_PRESCALE, lowbits(v, 8) & 32'hFE);
			bus(1'b1, ADDR_PORT_CONTROL, v & 32'h6F, d);
			rdchk("port_control", ADDR_PORT_CONTROL, v & 32'h6F);
			bus(1'b1, ADDR_FIFO_STATUS + 32'h0C, v, d);
			rdchk("unmapped", ADDR_FIFO_STATUS + 32'h0C, 32'h0);
		end
		// Role locked while enabled, silent slave
		bus(1'b1, ADDR_PORT_CONTROL, 32'h00, d);
		bus(1'b1, ADDR_PORT_CONTROL, 32'h10, d);
		bus(1'b1, ADDR_PORT_CONTROL, 32'h30, d);
		rdchk("role locked", ADDR_PORT_CONTROL, 32'h10);
		bus(1'b1, ADDR_PORT_CONTROL, 32'h60, d);
		bus(1'b1, ADDR_PORT_CONTROL, 32'h70, d);
		repeat (4) @(posedge hclk);
		chk("slave oe", 32'h0, {31'h0, serial_out_oe});
		bus(1'b1, ADDR_PORT_CONTROL, 32'h60, d);
		// Preload, loopback, overrun
		bus(1'b1, ADDR_PORT_CONTROL, 32'h0F, d);
		bus(1'b1, ADDR_FRAME_CONTROL, 32'h3, d);
		bus(1'b1, ADDR_CLOCK_PRESCALE, 32'h2, d);
		repeat (3) @(posedge hclk);
		chk("tx irq empty", 32'h1, {31'h0, tx_service_irq});
		for (int i = 0; i <= DEPTH; i++)
		begin
			v = rnd();
			if (i < DEPTH)
				w[i] = v[15:0];
			bus(1'b1, ADDR_FIFO_DATA, v, d);
		end
		repeat (3) @(posedge hclk);
		chk("tx irq full", 32'h0, {31'h0, tx_service_irq});
		rdchk("status full", ADDR_FIFO_STATUS, status_of(1'b1, 0, DEPTH));
		chk("frame idle", 32'h1, {31'h0, frame_out});
		bus(1'b1, ADDR_PORT_CONTROL, 32'h1F, d);
		wait_idle();
		chk("rx irq", 32'h1, {31'h0, rx_service_irq});
		rdchk("status drained", ADDR_FIFO_STATUS, status_of(1'b0, DEPTH, 0));
		bus(1'b1, ADDR_FIFO_DATA, rnd(), d);
		wait_idle();
		rdchk("irq status", ADDR_IRQ_STATUS_CLEAR, 32'h7);
		bus(1'b1, ADDR_IRQ_STATUS_CLEAR, rnd(), d);
		rdchk("irq cleared", ADDR_IRQ_STATUS_CLEAR, 32'h3);
		for (int i = 0; i < DEPTH; i++)
			rdchk("rx word", ADDR_FIFO_DATA, lowbits(32'(w[i]), 4));
		// Far end transfers, 16 and 8 bits
		for (int k = 0; k < 4; k++)
		begin
			v = rnd();
			n = (k < 2) ? 16 : 8;
			word_len <= 5'(n);
			reply <= v[31:16];
			bus(1'b1, ADDR_FRAME_CONTROL, (k < 2) ? 32'h070F : 32'h0707, d);
			bus(1'b1, ADDR_PORT_CONTROL, 32'h10, d);
			bus(1'b1, ADDR_FIFO_DATA, v, d);
			wait_idle();
			chk("far word", lowbits(v, n), lowbits(32'(rx_word), n));
			rdchk("reply word", ADDR_FIFO_DATA, lowbits(v >> 16, n));
		end
		// Loopback in other clock modes and formats
		bus(1'b1, ADDR_PORT_CONTROL, 32'h18, d);
		for (int k = 0; k < 3; k++)
		begin
			v = rnd();
			bus(1'b1, ADDR_FRAME_CONTROL, (k == 0) ? 32'h00C7 : (k == 1) ? 32'h0017 : 32'h0027, d);
			bus(1'b1, ADDR_FIFO_DATA, v, d);
			wait_idle();
			rdchk("loop word", ADDR_FIFO_DATA, (k == 2) ? 32'h0 : lowbits(v, 8));
		end
		summarize();
	end
endmodule : sspr_top_tb
